/* owc_pkg.sv */
// owc_pkg: constants, state codes and register record for the channel access block
// assumes a slot front end on the same 50 MHz clock that reports slot start and end
package owc_pkg;
   // memory function commands
   localparam logic [7:0]  CMD_RD_STATUS = 8'haa;
   localparam logic [7:0]  CMD_CHAN_ACC  = 8'hf5;
   // first control byte field positions
   localparam int          CB_CRC   = 0;
   localparam int          CB_SEL   = 2;
   localparam int          CB_IC    = 4;
   localparam int          CB_TOG   = 5;
   localparam int          CB_IM    = 6;
   localparam int          CB_CLR   = 7;
   // channel info byte field positions
   localparam int          IB_FF_A  = 0;
   localparam int          IB_FF_B  = 1;
   localparam int          IB_LVL_A = 2;
   localparam int          IB_LVL_B = 3;
   localparam int          IB_LAT_A = 4;
   localparam int          IB_LAT_B = 5;
   localparam int          IB_NCH   = 6;
   localparam int          IB_SUP   = 7;
   // channel select and crc mode codes
   localparam logic [1:0]  SEL_NONE = 2'h0;
   localparam logic [1:0]  SEL_B    = 2'h2;
   localparam logic [1:0]  SEL_AB   = 2'h3;
   localparam logic [1:0]  CRC_OFF  = 2'h0;
   localparam logic [1:0]  CRC_1    = 2'h1;
   localparam logic [1:0]  CRC_8    = 2'h2;
   localparam logic [5:0]  PKT_1    = 6'h01;
   localparam logic [5:0]  PKT_8    = 6'h08;
   localparam logic [5:0]  PKT_32   = 6'h20;
   localparam logic [15:0] CRC_POLY = 16'ha001;
   localparam logic [2:0]  STAT_LAST = 3'h7;
   localparam logic        HAS_CHAN_B = 1'b1;
   localparam logic        FF_RST   = 1'b1;
   // slot timing
   localparam int          CLK_NS      = 20;
   localparam int          WR1_MIN_NS  = 15000;
   localparam int          WR1_MAX_NS  = 60000;
   localparam int          WR0_MIN_NS  = 200;
   localparam int          WR0_MAX_NS  = 300;
   localparam logic [11:0] WR1_MIN_CYC = 12'((WR1_MIN_NS + CLK_NS - 1) / CLK_NS);
   localparam logic [11:0] WR1_MAX_CYC = 12'(WR1_MAX_NS / CLK_NS);
   localparam logic [11:0] WR0_MIN_CYC = 12'((WR0_MIN_NS + CLK_NS - 1) / CLK_NS);
   localparam logic [11:0] WR0_MAX_CYC = 12'(WR0_MAX_NS / CLK_NS);

   typedef enum logic [6:0] {
      ST_CMD  = 7'h01,
      ST_ARG  = 7'h02,
      ST_INFO = 7'h04,
      ST_CHAN = 7'h08,
      ST_CRC  = 7'h10,
      ST_SDAT = 7'h20,
      ST_IDLE = 7'h40
   } owc_state_type;

   typedef struct packed {
      owc_state_type st;
      owc_state_type ret;
      logic [4:0]    bcnt;
      logic [5:0]    pcnt;
      logic [7:0]    rx;
      logic [15:0]   tx;
      logic [7:0]    arg;
      logic [7:0]    cmd;
      logic [7:0]    ctl;
      logic [15:0]   crc;
      logic [2:0]    adr;
      logic          rd;
      logic          chb;
      logic          hb;
      logic          ha;
      logic [11:0]   scnt;
      logic [11:0]   pcd;
      logic          p_one;
      logic          pa_en;
      logic          pb_en;
      logic          pa_v;
      logic          pb_v;
      logic          ff_a;
      logic          ff_b;
      logic          lat_a;
      logic          lat_b;
      logic          tx_bit;
      logic          tx_en;
      logic          oe_a;
      logic          oe_b;
      logic          pin_lo;
   } owc_regs_type;

   localparam owc_regs_type REGS_RST = '{st: ST_CMD, ret: ST_IDLE, ff_a: FF_RST,
                                         ff_b: FF_RST, default: '0};

   // one bit of the reflected crc16, lsb first
   function automatic logic [15:0] owc_crc_step(input logic [15:0] c, input logic b);
      logic [15:0] s;
      s = {1'b0, c[15:1]};
      if (c[0] ^ b) s = s ^ CRC_POLY;
      return s;
   endfunction : owc_crc_step
endpackage : owc_pkg

/* owc_chan_access.sv */
// owc_chan_access: status read and pio channel access command interpreter
// assumes a slot front end on i_sys_clk that strips rom commands and
// reports each slot start, end and written bit; pins are open drain
`timescale 1ns/1ps
`default_nettype none

module owc_chan_access (
   // clock and reset
   input  wire logic        i_sys_clk,
   input  wire logic        i_rstn,
   // slot front end
   input  wire logic        i_bus_reset,
   input  wire logic        i_slot_start,
   input  wire logic        i_slot_end,
   input  wire logic        i_slot_bit,
   output var  logic        o_tx_en,
   output var  logic        o_tx_bit,
   // status memory contents, byte n at bits 8n+7..8n
   input  wire logic [63:0] i_status_mem,
   // channel pins and supply sense
   input  wire logic        i_pin_a,
   output var  logic        o_pin_a,
   output var  logic        o_pin_a_oe,
   input  wire logic        i_pin_b,
   output var  logic        o_pin_b,
   output var  logic        o_pin_b_oe,
   input  wire logic        i_ext_supply
);
   import owc_pkg::*;

   owc_regs_type r;
   owc_regs_type next_r;
   logic [2:0]   sa;
   logic [2:0]   sb;
   logic [1:0]   sv;
   logic         edge_a;
   logic         edge_b;
   logic         lvl_a;
   logic         lvl_b;
   logic [1:0]   sel;
   logic         sync_ab;
   logic         wr_go;

   ////////////////////////////////////////////////////////////////////////
   // pin synchronisers; third stage only feeds the edge detect
   always_ff @(posedge i_sys_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         sa <= 3'h7;
         sb <= 3'h7;
         sv <= 2'h0;
      end else begin
         sa <= {sa[1:0], i_pin_a};
         sb <= {sb[1:0], i_pin_b};
         sv <= {sv[0], i_ext_supply};
      end
   end

   assign lvl_a   = sa[1];
   assign lvl_b   = sb[1];
   assign edge_a  = sa[1] ^ sa[2];
   assign edge_b  = sb[1] ^ sb[2];
   assign sel     = r.ctl[CB_SEL +: 2];
   assign sync_ab = (sel == SEL_AB) && r.ctl[CB_IC];
   // a write slot that commits a pending pin change
   assign wr_go   = i_slot_end && (r.st == ST_CHAN) && !r.rd && !(sync_ab && !r.chb);

   ////////////////////////////////////////////////////////////////////////
   // protocol, slot timing and channel state
   always_comb begin
      logic       bitv;
      logic       bend;
      logic [5:0] pk;
      next_r = r;
      bitv   = r.tx_en ? r.tx_bit : i_slot_bit;
      bend   = (r.bcnt == 5'h07);
      pk     = (r.ctl[CB_CRC +: 2] == CRC_1) ? PKT_1 :
               (r.ctl[CB_CRC +: 2] == CRC_8) ? PKT_8 : PKT_32;
      if (i_slot_start) next_r.scnt = '0;
      else if (r.scnt != 12'hfff) next_r.scnt = 12'(r.scnt + 12'h001);
      if (r.pcd != '0) next_r.pcd = 12'(r.pcd - 12'h001);
      if (r.pcd == 12'h001) begin
         if (r.pa_en) next_r.ff_a = r.pa_v;
         if (r.pb_en) next_r.ff_b = r.pb_v;
         next_r.pa_en = 1'b0;
         next_r.pb_en = 1'b0;
      end
      next_r.oe_a = ~r.ff_a;
      next_r.oe_b = ~r.ff_b & HAS_CHAN_B;

      // present the bit for this slot
      if (i_slot_start) begin
         next_r.tx_en = 1'b0;
         unique case (r.st)
            ST_INFO, ST_CRC, ST_SDAT: begin
               next_r.tx_en  = 1'b1;
               next_r.tx_bit = r.tx[0];
            end
            ST_CHAN: if (r.rd) begin
               next_r.tx_en = 1'b1;
               if (sync_ab) begin
                  // b is held from the a slot; its own slot samples nothing
                  if (!r.chb) begin
                     next_r.tx_bit = lvl_a;
                     next_r.hb     = lvl_b;
                  end else begin
                     next_r.tx_bit = r.hb;
                  end
               end else begin
                  next_r.tx_bit = r.chb ? lvl_b : lvl_a;
               end
            end
            ST_CMD, ST_ARG, ST_IDLE: ;
            default: next_r.st = ST_IDLE;
         endcase
      end

      // take the bit at slot end
      if (i_slot_end) begin
         next_r.tx_en = 1'b0;
         next_r.rx    = {bitv, r.rx[7:1]};
         next_r.tx    = {1'b1, r.tx[15:1]};
         next_r.bcnt  = 5'(r.bcnt + 5'h01);
         if (r.st != ST_CRC) next_r.crc = owc_crc_step(r.crc, bitv);
         unique case (r.st)
            ST_CMD: if (bend) begin
               next_r.bcnt = '0;
               next_r.cmd  = next_r.rx;
               next_r.pcnt = '0;
               next_r.st   = (next_r.rx == CMD_RD_STATUS || next_r.rx == CMD_CHAN_ACC) ?
                             ST_ARG : ST_IDLE;
            end
            ST_ARG: if (bend) begin
               next_r.bcnt = '0;
               if (r.pcnt == '0) begin
                  next_r.arg  = next_r.rx;
                  next_r.pcnt = 6'h01;
               end else if (r.cmd == CMD_RD_STATUS) begin
                  // channel crc mode is not consulted here
                  next_r.adr = r.arg[2:0];
                  next_r.tx  = ~next_r.crc;
                  next_r.st  = ST_CRC;
                  next_r.ret = ST_SDAT;
               end else begin
                  // second control byte is reserved and not decoded
                  next_r.ctl = r.arg;
                  next_r.rd  = r.arg[CB_IM];
                  next_r.chb = (r.arg[CB_SEL +: 2] == SEL_B);
                  if (r.arg[CB_CLR]) begin
                     next_r.lat_a = 1'b0;
                     next_r.lat_b = 1'b0;
                  end
                  next_r.tx[IB_FF_A]  = r.ff_a;
                  next_r.tx[IB_FF_B]  = r.ff_b;
                  next_r.tx[IB_LVL_A] = lvl_a;
                  next_r.tx[IB_LVL_B] = lvl_b;
                  next_r.tx[IB_LAT_A] = next_r.lat_a;
                  next_r.tx[IB_LAT_B] = next_r.lat_b;
                  next_r.tx[IB_NCH]   = HAS_CHAN_B;
                  next_r.tx[IB_SUP]   = sv[1];
                  next_r.tx[15:8]     = 8'hff;
                  next_r.st = (r.arg[CB_SEL +: 2] == SEL_NONE) ? ST_IDLE : ST_INFO;
               end
            end
            ST_INFO: if (bend) begin
               next_r.bcnt = '0;
               next_r.pcnt = '0;
               next_r.st   = ST_CHAN;
            end
            ST_CHAN: begin
               if (!r.rd) begin
                  if (sync_ab && !r.chb) begin
                     next_r.ha = bitv;
                  end else if (sync_ab) begin
                     next_r.pa_en = 1'b1;
                     next_r.pb_en = 1'b1;
                     next_r.pa_v  = r.ha;
                     next_r.pb_v  = bitv;
                  end else if (r.chb) begin
                     next_r.pb_en = 1'b1;
                     next_r.pb_v  = bitv;
                  end else begin
                     next_r.pa_en = 1'b1;
                     next_r.pa_v  = bitv;
                  end
                  if (wr_go) begin
                     next_r.p_one = bitv;
                     if (!bitv) next_r.pcd = WR0_MIN_CYC;
                     else if (r.scnt < WR1_MIN_CYC) next_r.pcd = 12'(WR1_MIN_CYC - r.scnt);
                     else next_r.pcd = 12'h001;
                  end
               end
               if (sel == SEL_AB) next_r.chb = ~r.chb;
               if (bend) begin
                  next_r.bcnt = '0;
                  if (r.ctl[CB_TOG]) next_r.rd = ~r.rd;
                  next_r.pcnt = 6'(r.pcnt + 6'h01);
                  if (r.ctl[CB_CRC +: 2] != CRC_OFF && next_r.pcnt == pk) begin
                     next_r.pcnt = '0;
                     next_r.tx   = ~next_r.crc;
                     next_r.st   = ST_CRC;
                     next_r.ret  = ST_CHAN;
                  end
               end
            end
            ST_CRC: if (r.bcnt == 5'h0f) begin
               next_r.bcnt = '0;
               next_r.crc  = '0;
               next_r.st   = r.ret;
               next_r.tx   = {8'hff, i_status_mem[8 * r.adr +: 8]};
            end
            ST_SDAT: if (bend) begin
               next_r.bcnt = '0;
               if (r.adr == STAT_LAST) begin
                  next_r.tx  = ~next_r.crc;
                  next_r.st  = ST_CRC;
                  next_r.ret = ST_IDLE;
               end else begin
                  next_r.adr = 3'(r.adr + 3'h1);
                  next_r.tx  = {8'hff, i_status_mem[8 * next_r.adr +: 8]};
               end
            end
            ST_IDLE: ;
            default: next_r.st = ST_IDLE;
         endcase
      end

      // a bus reset restarts the command; pins and latches keep their state
      if (i_bus_reset) begin
         next_r.st    = ST_CMD;
         next_r.bcnt  = '0;
         next_r.pcnt  = '0;
         next_r.crc   = '0;
         next_r.tx_en = 1'b0;
      end
      // set after clear so an edge in the clearing cycle is kept
      if (edge_a) next_r.lat_a = 1'b1;
      if (edge_b) next_r.lat_b = 1'b1;
   end

   always_ff @(posedge i_sys_clk or negedge i_rstn) begin
      if (!i_rstn) r <= REGS_RST;
      else r <= next_r;
   end

   assign o_tx_en    = r.tx_en;
   assign o_tx_bit   = r.tx_bit;
   assign o_pin_a    = r.pin_lo;
   assign o_pin_b    = r.pin_lo;
   assign o_pin_a_oe = r.oe_a;
   assign o_pin_b_oe = r.oe_b;

   ////////////////////////////////////////////////////////////////////////
   // checks
   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (!i_rstn);

   sequence s_wr0;
      wr_go && !i_slot_bit && !i_bus_reset;
   endsequence
   sequence s_rd_a;
      i_slot_start && r.st == ST_CHAN && r.rd && sel == 2'h1 && !i_bus_reset;
   endsequence

   a_info_after_ctl: assert property ($rose(r.st == ST_INFO) |-> $past(r.st) == ST_ARG)
      else $error("info byte not preceded by control bytes");
   a_sel_not_zero: assert property (r.st == ST_CHAN |-> sel != SEL_NONE)
      else $error("channel access running with forbidden select");
   a_rd_sample: assert property (s_rd_a |=> o_tx_bit == $past(lvl_a) && o_tx_en)
      else $error("single channel read bit not sampled at slot start");
   a_wr0_delay: assert property (s_wr0 |=> r.pcd == WR0_MIN_CYC ##9 r.pcd == 12'h001)
      else $error("write zero apply delay wrong");
   a_wr1_window: assert property (r.pcd == 12'h001 && r.p_one
                                  |-> r.scnt >= WR1_MIN_CYC - 12'h001)
      else $error("write one applied too early");
   a_latch_set: assert property (edge_a |=> r.lat_a)
      else $error("activity latch missed an edge");
   a_latch_keep: assert property (r.lat_a && !(i_slot_end && r.st == ST_ARG) |=> r.lat_a)
      else $error("activity latch dropped without clear");
   a_async_alt: assert property (i_slot_end && r.st == ST_CHAN && sel == SEL_AB
                                 && !i_bus_reset |=> r.chb != $past(r.chb))
      else $error("two channel access did not alternate");
   a_dir_fixed: assert property (r.st == ST_CHAN && $past(r.st) == ST_CHAN && !r.ctl[CB_TOG]
                                 |-> r.rd == $past(r.rd))
      else $error("direction changed with toggle off");
   a_oe_follow: assert property (##1 !r.ff_a |=> o_pin_a_oe)
      else $error("flip-flop zero did not pull pin low");
endmodule : owc_chan_access
`default_nettype wire

/* owc_master_model.sv */
// owc_master_model: behavioural one-wire bus master as seen through the slot front end
// assumes the device samples the slot pulses on the rising edge of i_sys_clk
`timescale 1ns/1ps
`default_nettype none
module owc_master_model (
   // clock
   input  wire logic i_sys_clk,
   // slot pulses toward the device
   output var  logic o_bus_reset,
   output var  logic o_slot_start,
   output var  logic o_slot_end,
   output var  logic o_slot_bit,
   // device answer
   input  wire logic i_tx_en,
   input  wire logic i_tx_bit
);
   int n_tx = 0;

   initial begin
      o_bus_reset  = 1'b0;
      o_slot_start = 1'b0;
      o_slot_end   = 1'b0;
      o_slot_bit   = 1'b1;
   end

   ////////////////////////////////////////////////////////////////////////////////
   task automatic bus_reset();
      @(negedge i_sys_clk) o_bus_reset = 1'b1;
      @(negedge i_sys_clk) o_bus_reset = 1'b0;
      repeat (4) @(negedge i_sys_clk);
   endtask : bus_reset

   // a read slot is a write-one slot that the device may pull low
   task automatic slot(input logic b, input int low, input int gap, output logic r);
      @(negedge i_sys_clk) o_slot_start = 1'b1;
      @(negedge i_sys_clk) o_slot_start = 1'b0;
      repeat (low) @(negedge i_sys_clk);
      o_slot_end = 1'b1;
      o_slot_bit = b;
      // pulled-up line reads high unless the device sends a zero
      r = !(i_tx_en && !i_tx_bit);
      if (i_tx_en === 1'b1) n_tx++;
      @(negedge i_sys_clk) o_slot_end = 1'b0;
      // bit is qualified by the end pulse only, so do not leave it looking valid
      o_slot_bit = !b;
      repeat (gap) @(negedge i_sys_clk);
   endtask : slot

   task automatic wr_byte(input logic [7:0] v, input int gap);
      logic r;
      for (int i = 0; i < 8; i++) slot(v[i], 3, gap, r);
   endtask : wr_byte

   task automatic rd_bits(input int n, output logic [15:0] v);
      logic r;
      v = '1;
      for (int i = 0; i < n; i++) begin
         slot(1'b1, 3, 4, r);
         v[i] = r;
      end
   endtask : rd_bits
endmodule : owc_master_model
`default_nettype wire

/* tb_owc_chan_access.sv */
// tb_owc_chan_access: self-checking bench for the status read and channel access block
// assumes the master model stands in for the slot front end; pins modelled open drain
`timescale 1ns/1ps
`default_nettype none
module tb_owc_chan_access;
   import owc_pkg::*;
   logic        i_sys_clk, i_rstn;
   logic        bus_reset, slot_start, slot_end, slot_bit, tx_en, tx_bit;
   logic        pin_a_ext, pin_b_ext, ext_supply, o_pin_a, o_pin_b, oe_a, oe_b;
   logic [63:0] status_mem;
   logic [15:0] crc, v, w, c;
   logic        b, prev, r;
   logic [7:0]  pat;
   int          n_errors = 0;
   int          check_count = 0;
   // open drain: a driven pin shows the drive level, else the outside level
   wire logic   pin_a = oe_a ? o_pin_a : pin_a_ext;
   wire logic   pin_b = oe_b ? o_pin_b : pin_b_ext;

   owc_chan_access owc_chan_access_i (
      .i_sys_clk(i_sys_clk), .i_rstn(i_rstn), .i_bus_reset(bus_reset),
      .i_slot_start(slot_start), .i_slot_end(slot_end), .i_slot_bit(slot_bit),
      .o_tx_en(tx_en), .o_tx_bit(tx_bit), .i_status_mem(status_mem),
      .i_pin_a(pin_a), .o_pin_a(o_pin_a), .o_pin_a_oe(oe_a),
      .i_pin_b(pin_b), .o_pin_b(o_pin_b), .o_pin_b_oe(oe_b), .i_ext_supply(ext_supply));

   owc_master_model owc_master_model_i (
      .i_sys_clk(i_sys_clk), .o_bus_reset(bus_reset), .o_slot_start(slot_start),
      .o_slot_end(slot_end), .o_slot_bit(slot_bit), .i_tx_en(tx_en), .i_tx_bit(tx_bit));

   initial begin
      i_sys_clk = 1'b0;
      forever #10 i_sys_clk = ~i_sys_clk;
   end

   ////////////////////////////////////////////////////////////////////////////////
   task automatic summarize();
      if (n_errors == 0 && check_count > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : summarize

   task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string msg);
      check_count++;
      if (seen !== exp) begin
         n_errors++;
         $display("[FAIL] %0t %s seen %h expected %h", $time, msg, seen, exp);
      end
   endtask : check

   task automatic crc_byte(input logic [7:0] d);
      for (int i = 0; i < 8; i++)
         crc = (crc[0] ^ d[i]) ? ({1'b0, crc[15:1]} ^ 16'ha001) : {1'b0, crc[15:1]};
   endtask : crc_byte

   task automatic send(input logic [7:0] d);
      owc_master_model_i.wr_byte(d, 20);
      crc_byte(d);
   endtask : send

   task automatic recv(input int n, output logic [15:0] d);
      owc_master_model_i.rd_bits(n, d);
   endtask : recv

   task automatic start_acc(input logic [7:0] ctl, input logic [7:0] info);
      owc_master_model_i.bus_reset();
      crc = '0;
      send(CMD_CHAN_ACC);
      send(ctl);
      send(8'hff);
      recv(8, v);
      check(v, {8'hff, info}, "info byte");
      crc_byte(v[7:0]);
   endtask : start_acc

   task automatic tx_count(output logic [15:0] n);
      n = 16'(owc_master_model_i.n_tx);
   endtask : tx_count

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (60000) @(posedge i_sys_clk);
      n_errors++;
      summarize();
   end

   initial begin
      i_rstn = 1'b0;
      pin_a_ext = 1'b1;
      pin_b_ext = 1'b1;
      ext_supply = 1'b0;
      status_mem = 64'h8877_6655_4433_2211;
      repeat (12) @(negedge i_sys_clk);
      check(16'({tx_en, oe_a, oe_b}), 16'h0, "reset outputs");
      i_rstn = 1'b1;
      // edge on a sets its latch, then control bit seven clears it
      pin_a_ext = 1'b0;
      repeat (5) @(negedge i_sys_clk);
      pin_a_ext = 1'b1;
      repeat (5) @(negedge i_sys_clk);
      start_acc(8'hc4, 8'h4f);
      pat = 8'h5a;
      for (int i = 0; i < 8; i++) begin
         pin_a_ext = pat[i];
         repeat (3) @(negedge i_sys_clk);
         recv(1, v);
         w[i] = v[0];
      end
      check(16'(w[7:0]), 16'h005a, "single read");
      pin_a_ext = 1'b1;
      ext_supply = 1'b1;
      // write byte 35 to a with toggling, then one read byte
      start_acc(8'h24, 8'hdf);
      pat = 8'h35;
      for (int i = 0; i < 8; i++) begin
         b = pat[i];
         prev = oe_a;
         owc_master_model_i.slot(b, 3, 0, r);
         repeat (9) @(negedge i_sys_clk);
         check(16'(oe_a), 16'(prev), "early change");
         repeat (5) @(negedge i_sys_clk);
         check(16'(oe_a), 16'(b ? prev : 1'b1), "write zero");
         repeat (726) @(negedge i_sys_clk);
         check(16'(oe_a), 16'(b ? prev : 1'b1), "write one early");
         repeat (2300) @(negedge i_sys_clk);
         check(16'(oe_a), 16'(!b), "write one");
      end
      tx_count(c);
      recv(8, v);
      check(v, 16'hff00, "toggled read");
      tx_count(w);
      check(w - c, 16'h0008, "toggled read slots");
      // both channels, alternating reads starting with a, crc after eight bytes
      start_acc(8'h4e, 8'hda);
      for (int k = 0; k < 8; k++) begin
         recv(8, v);
         check(v, 16'hffaa, "async read");
         crc_byte(8'haa);
      end
      recv(16, v);
      check(v, ~crc, "crc after eight bytes");
      // both channels together, b sent from the held sample, crc per byte
      start_acc(8'h5d, 8'hda);
      for (int k = 0; k < 4; k++) begin
         pin_b_ext = k[0];
         repeat (3) @(negedge i_sys_clk);
         recv(1, v);
         w[2*k] = v[0];
         pin_b_ext = !k[0];
         repeat (3) @(negedge i_sys_clk);
         recv(1, v);
         w[2*k+1] = v[0];
      end
      check(16'(w[7:0]), 16'h0088, "sync read");
      crc_byte(8'h88);
      recv(16, v);
      check(v, ~crc, "channel crc");
      // status read from byte six: crc of command and address, data, crc of data
      owc_master_model_i.bus_reset();
      crc = '0;
      send(CMD_RD_STATUS);
      send(8'h06);
      send(8'h00);
      recv(16, v);
      check(v, ~crc, "address crc");
      crc = '0;
      recv(16, v);
      check(v, status_mem[63:48], "status bytes");
      crc_byte(v[7:0]);
      crc_byte(v[15:8]);
      recv(16, v);
      check(v, ~crc, "status crc");
      tx_count(c);
      recv(8, v);
      tx_count(w);
      check(w - c, 16'h0000, "silent after crc");
      // select code zero is refused: no info byte
      owc_master_model_i.bus_reset();
      send(CMD_CHAN_ACC);
      send(8'h40);
      send(8'hff);
      tx_count(c);
      recv(8, v);
      tx_count(w);
      check(w - c, 16'h0000, "select zero");
      // both channels written together: a is held until b arrives
      start_acc(8'h1c, 8'hf2);
      owc_master_model_i.slot(1'b1, 3, 0, r);
      repeat (3050) @(negedge i_sys_clk);
      check(16'({oe_a, oe_b}), 16'h0002, "sync write held");
      owc_master_model_i.slot(1'b0, 3, 0, r);
      repeat (14) @(negedge i_sys_clk);
      check(16'({oe_a, oe_b}), 16'h0001, "sync write both");
      check(16'({pin_a, pin_b}), 16'h0002, "pin levels");
      // both channels written in turn, a first, each with its own timing
      start_acc(8'h0c, 8'hf5);
      owc_master_model_i.slot(1'b0, 3, 0, r);
      repeat (3050) @(negedge i_sys_clk);
      check(16'({oe_a, oe_b}), 16'h0003, "async write a");
      owc_master_model_i.slot(1'b1, 3, 0, r);
      repeat (14) @(negedge i_sys_clk);
      check(16'({oe_a, oe_b}), 16'h0003, "async write b early");
      repeat (3050) @(negedge i_sys_clk);
      check(16'({oe_a, oe_b}), 16'h0002, "async write b");
      summarize();
   end
endmodule : tb_owc_chan_access
`default_nettype wire
